// file: verilog/pwc_pkg.sv
package pwc_pkg;
	// register map, word offsets on the plain register port
	localparam logic [3:0] PWC_ADDR_PCR = 4'h0;
	localparam logic [3:0] PWC_ADDR_CLK = 4'h1;
	localparam logic [3:0] PWC_ADDR_STAT = 4'h2;
	// field positions in power_control_register
	localparam int PWC_BIT_SLEEP = 0;
	localparam int PWC_BIT_DEEP = 1;
	localparam int PWC_BIT_GF0 = 2;
	localparam int PWC_BIT_GF1 = 3;
	// field position in the clock register
	localparam int PWC_BIT_HALVE = 0;
	// reset values
	localparam logic [7:0] PWC_PCR_RST = 8'h00;
	localparam logic PWC_HALVE_RST = 1'b0;
	// clock division ratio under the halving option
	localparam int PWC_HALVE_DIV = 2;

	typedef enum logic [1:0] {
		PWC_ST_RUN = 2'b00,
		PWC_ST_IDLE = 2'b01,
		PWC_ST_DOWN = 2'b10
	} pwc_state_type;
endpackage

// file: verilog/pwc_clk_if.sv
interface pwc_clk_if;
	logic halve;
	logic cpu_run;
	logic periph_run;
	logic core_tick;
	logic periph_tick;
	modport ctrl (output halve, output cpu_run, output periph_run,
		input core_tick, input periph_tick);
	modport div (input halve, input cpu_run, input periph_run,
		output core_tick, output periph_tick);
endinterface

// file: verilog/pwc_sync.sv
module pwc_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// asynchronous level in, synchronised level out
	input wire logic din,
	output logic dout
);
	logic meta_r;

	// two-stage synchroniser; meta_r feeds only the second stage
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule

// file: verilog/pwc_clkdiv.sv
module pwc_clkdiv
	import pwc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// control from the sequencer
	pwc_clk_if.div cif
);
	logic [$clog2(PWC_HALVE_DIV)-1:0] phase_r;
	logic tick;

	// phase counts only while halved, held at zero otherwise; wraps at the division ratio
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_r <= '0;
		end else if (!cif.halve || phase_r == $bits(phase_r)'(PWC_HALVE_DIV - 1)) begin
			phase_r <= '0;
		end else begin
			phase_r <= phase_r + 1'b1;
		end
	end

	// every cycle at full speed, one in two when halved
	assign tick = !cif.halve || (phase_r == $bits(phase_r)'(PWC_HALVE_DIV - 1));

	// enables are gated by the run permits from the sequencer
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cif.core_tick <= 1'b0;
			cif.periph_tick <= 1'b0;
		end else begin
			cif.core_tick <= tick && cif.cpu_run;
			cif.periph_tick <= tick && cif.periph_run;
		end
	end
endmodule

// file: verilog/pwc_ctrl.sv
module pwc_ctrl
	import pwc_pkg::*;
(
	// clock and resets
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic rst_pin,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_r,
	// interrupt controller
	input wire logic irq_enabled_pending,
	input wire logic wake_pin,
	// cpu core
	output logic cpu_clk_en_r,
	output logic cpu_hold_r,
	output logic irq_vector_r,
	// clock tree
	output logic periph_clk_en_r,
	output logic intc_clk_en_r,
	output logic osc_en_r,
	output pwc_pkg::pwc_state_type mode_r
);
	import pwc_pkg::*;

	pwc_clk_if cif ();
	pwc_state_type state_r;
	logic sleep_req_r;
	logic deep_req_r;
	logic gf0_r;
	logic gf1_r;
	logic halve_r;
	logic wake_s;
	logic pcr_wr;
	logic [7:0] pcr_val;
	logic [7:0] rdata_nxt;

	// the wake pin comes from outside and is synchronised before use
	pwc_sync u_wake_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.din(wake_pin),
		.dout(wake_s)
	);

	pwc_clkdiv u_div (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.cif(cif)
	);

	assign pcr_wr = reg_wr && reg_addr == PWC_ADDR_PCR;

	// sequencer and sleep bit share the pin clear; the pin acts with no clock edge
	// pin clears sleep
	always_ff @(posedge clk_sys or negedge resetn or posedge rst_pin) begin
		if (!resetn) begin
			state_r <= PWC_ST_RUN;
			sleep_req_r <= PWC_PCR_RST[PWC_BIT_SLEEP];
		end else if (rst_pin) begin
			state_r <= PWC_ST_RUN;
			sleep_req_r <= 1'b0;
		end else begin
			unique case (state_r)
				PWC_ST_RUN: begin
					if (pcr_wr) begin
						sleep_req_r <= reg_wdata[PWC_BIT_SLEEP];
						if (reg_wdata[PWC_BIT_DEEP]) begin
							state_r <= PWC_ST_DOWN;
						end else if (reg_wdata[PWC_BIT_SLEEP]) begin
							state_r <= PWC_ST_IDLE;
						end
					end
				end
				PWC_ST_IDLE: begin
					if (irq_enabled_pending) begin
						sleep_req_r <= 1'b0;
						state_r <= PWC_ST_RUN;
					end
				end
				PWC_ST_DOWN: begin
					// both bits drop so idle is skipped
					if (wake_s) begin
						sleep_req_r <= 1'b0;
						state_r <= PWC_ST_RUN;
					end
				end
				default: begin
					state_r <= PWC_ST_RUN;
				end
			endcase
		end
	end

	// deep-sleep bit follows software and is dropped by hardware on wake
	// deep bit requests power-down
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			deep_req_r <= PWC_PCR_RST[PWC_BIT_DEEP];
		end else if (pcr_wr && state_r == PWC_ST_RUN) begin
			deep_req_r <= reg_wdata[PWC_BIT_DEEP];
		end else if (state_r == PWC_ST_DOWN && wake_s) begin
			deep_req_r <= 1'b0;
		end
	end

	// general flags are plain software storage; hardware never touches them
	// general flags
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			gf0_r <= PWC_PCR_RST[PWC_BIT_GF0];
			gf1_r <= PWC_PCR_RST[PWC_BIT_GF1];
		end else if (pcr_wr) begin
			gf0_r <= reg_wdata[PWC_BIT_GF0];
			gf1_r <= reg_wdata[PWC_BIT_GF1];
		end
	end

	// halving option may change in any mode; it only takes effect while clocks run
	// run-time halving
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			halve_r <= PWC_HALVE_RST;
		end else if (reg_wr && reg_addr == PWC_ADDR_CLK) begin
			halve_r <= reg_wdata[PWC_BIT_HALVE];
		end
	end

	// run permits to the divider; decoded from the next state so entry costs no cycle
	// cpu stops, peripherals run except in power-down
	always_comb begin
		cif.halve = halve_r;
		cif.cpu_run = 1'b1;
		cif.periph_run = 1'b1;
		if (pcr_wr && state_r == PWC_ST_RUN && (reg_wdata[PWC_BIT_SLEEP] || reg_wdata[PWC_BIT_DEEP])) begin
			cif.cpu_run = 1'b0;
			cif.periph_run = !reg_wdata[PWC_BIT_DEEP];
		end else if (state_r == PWC_ST_IDLE) begin
			cif.cpu_run = irq_enabled_pending;
		end else if (state_r == PWC_ST_DOWN) begin
			cif.cpu_run = wake_s;
			cif.periph_run = wake_s;
		end
	end

	// registered outputs toward core and clock tree
	// core frozen holds pc and psw
	// hold blocks sfr and ram writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cpu_clk_en_r <= 1'b0;
			periph_clk_en_r <= 1'b0;
			intc_clk_en_r <= 1'b0;
			osc_en_r <= 1'b1;
			cpu_hold_r <= 1'b0;
			mode_r <= PWC_ST_RUN;
		end else begin
			cpu_clk_en_r <= cif.core_tick;
			periph_clk_en_r <= cif.periph_tick;
			intc_clk_en_r <= state_r != PWC_ST_DOWN;
			osc_en_r <= state_r != PWC_ST_DOWN;
			cpu_hold_r <= state_r != PWC_ST_RUN;
			mode_r <= state_r;
		end
	end

	// one-cycle request to vector into the handler; the core pushes the held pc,
	// which already points past the idle-setting instruction
	// return resumes after idle request
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_vector_r <= 1'b0;
		end else begin
			irq_vector_r <= state_r == PWC_ST_IDLE && irq_enabled_pending && !rst_pin;
		end
	end

	// read mux; unmapped offsets read as zero
	assign pcr_val = {4'h0, gf1_r, gf0_r, deep_req_r, sleep_req_r};
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				PWC_ADDR_PCR: rdata_nxt = pcr_val;
				PWC_ADDR_CLK: rdata_nxt = {7'h00, halve_r};
				PWC_ADDR_STAT: rdata_nxt = {6'h00, state_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_r <= 8'h00;
		end else begin
			reg_rdata_r <= rdata_nxt;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn || rst_pin);

	property p_idle_entry;
		state_r == PWC_ST_RUN && pcr_wr && reg_wdata[PWC_BIT_SLEEP] && !reg_wdata[PWC_BIT_DEEP]
			|=> state_r == PWC_ST_IDLE ##1 !cpu_clk_en_r;
	endproperty
	a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

	property p_both_down;
		state_r == PWC_ST_RUN && pcr_wr && reg_wdata[PWC_BIT_SLEEP] && reg_wdata[PWC_BIT_DEEP]
			|=> state_r == PWC_ST_DOWN;
	endproperty
	a_both_down: assert property (p_both_down) else $error("both bits did not pick power-down");

	property p_no_idle_after_down;
		state_r == PWC_ST_DOWN && wake_s |=> state_r == PWC_ST_RUN && !sleep_req_r && !deep_req_r;
	endproperty
	a_no_idle_after_down: assert property (p_no_idle_after_down) else $error("idle after power-down");

	property p_idle_cpu_stopped;
		state_r == PWC_ST_IDLE && !irq_enabled_pending [*2] |-> !cpu_clk_en_r;
	endproperty
	a_idle_cpu_stopped: assert property (p_idle_cpu_stopped) else $error("cpu clocked in idle");

	property p_idle_periph_runs;
		state_r == PWC_ST_IDLE && !halve_r && !$past(halve_r) && $past(state_r) == PWC_ST_IDLE
			##1 state_r == PWC_ST_IDLE |-> periph_clk_en_r;
	endproperty
	a_idle_periph_runs: assert property (p_idle_periph_runs) else $error("peripherals stopped in idle");

	property p_wake;
		state_r == PWC_ST_IDLE && irq_enabled_pending
			|=> !sleep_req_r && irq_vector_r && state_r == PWC_ST_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("interrupt did not end idle");

	property p_hold;
		state_r != PWC_ST_RUN |=> cpu_hold_r;
	endproperty
	a_hold: assert property (p_hold) else $error("core not held");

	property p_down_frozen;
		state_r == PWC_ST_DOWN && $past(state_r) == PWC_ST_DOWN && !wake_s
			|=> !osc_en_r && !cpu_clk_en_r;
	endproperty
	a_down_frozen: assert property (p_down_frozen) else $error("clocks run in power-down");

	property p_flags;
		pcr_wr |=> gf0_r == $past(reg_wdata[PWC_BIT_GF0]) && gf1_r == $past(reg_wdata[PWC_BIT_GF1]);
	endproperty
	a_flags: assert property (p_flags) else $error("general flags not stored");

	property p_halve;
		halve_r && state_r == PWC_ST_RUN && $past(state_r) == PWC_ST_RUN [*3]
			|-> !(periph_clk_en_r && $past(periph_clk_en_r));
	endproperty
	a_halve: assert property (p_halve) else $error("halved clock ticks twice in a row");

	// deep-sleep bit alone must also reach power-down
	property p_deep_entry;
		state_r == PWC_ST_RUN && pcr_wr && reg_wdata[PWC_BIT_DEEP]
			|=> state_r == PWC_ST_DOWN;
	endproperty
	a_deep_entry: assert property (p_deep_entry) else $error("deep bit did not pick power-down");

	// without an enabled request idle must not end on its own
	property p_idle_waits;
		state_r == PWC_ST_IDLE && !irq_enabled_pending
			|=> state_r == PWC_ST_IDLE && sleep_req_r;
	endproperty
	a_idle_waits: assert property (p_idle_waits) else $error("idle left without interrupt");

	property p_intc_idle;
		state_r == PWC_ST_IDLE
			|=> intc_clk_en_r;
	endproperty
	a_intc_idle: assert property (p_intc_idle) else $error("interrupt clock stopped in idle");

	// core sees hold and idle mode together, so no sfr or ram write slips through
	property p_retain_idle;
		state_r == PWC_ST_IDLE
			|=> cpu_hold_r && mode_r == PWC_ST_IDLE;
	endproperty
	a_retain_idle: assert property (p_retain_idle) else $error("core not held in idle");

	// the vector only follows an idle cycle, so the held pc is the return point
	property p_vector_src;
		irq_vector_r
			|-> $past(state_r) == PWC_ST_IDLE;
	endproperty
	a_vector_src: assert property (p_vector_src) else $error("vector outside idle wake");

	property p_vector_pulse;
		irq_vector_r
			|=> !irq_vector_r;
	endproperty
	a_vector_pulse: assert property (p_vector_pulse) else $error("vector longer than one cycle");

	property p_down_periph;
		state_r == PWC_ST_DOWN && $past(state_r) == PWC_ST_DOWN && !wake_s
			|=> !periph_clk_en_r && !intc_clk_en_r;
	endproperty
	a_down_periph: assert property (p_down_periph) else $error("peripherals clocked in power-down");

	// cover the main paths: idle wake, power-down wake, both bits, halved clock
	c_both_bits: cover property (state_r == PWC_ST_RUN && pcr_wr && reg_wdata[PWC_BIT_SLEEP] && reg_wdata[PWC_BIT_DEEP]);
	c_idle_wake: cover property (state_r == PWC_ST_IDLE ##[1:20] irq_vector_r);
	c_down_wake: cover property (state_r == PWC_ST_DOWN ##[1:20] state_r == PWC_ST_RUN);
	c_halved: cover property (halve_r && periph_clk_en_r);
endmodule

// file: sim/pwc_cpu_model.sv
// behavioural stand-in for the core and the interrupt controller
module pwc_cpu_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// from the power controller
	input wire logic cpu_clk_en_r,
	input wire logic cpu_hold_r,
	input wire logic irq_vector_r,
	// bench side
	input wire logic irq_req,
	output logic irq_enabled_pending,
	output logic [15:0] cpu_pc
);
	timeunit 1ns;
	timeprecision 100ps;

	// level pending until the vector is taken, so a slow wake is not lost
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			irq_enabled_pending <= 1'b0;
		else if (irq_vector_r)
			irq_enabled_pending <= 1'b0;
		else if (irq_req)
			irq_enabled_pending <= 1'b1;
	end

	// fetch pointer moves only on a core tick outside hold
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			cpu_pc <= 16'h0000;
		else if (cpu_clk_en_r && !cpu_hold_r)
			cpu_pc <= cpu_pc + 16'h0001;
	end
endmodule

// file: sim/tb.sv
module tb import pwc_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_sys, resetn, rst_pin, reg_wr, reg_rd, wake_pin, irq_req;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_r, rd_val;
	logic irq_enabled_pending, cpu_clk_en_r, cpu_hold_r, irq_vector_r;
	logic periph_clk_en_r, intc_clk_en_r, osc_en_r;
	pwc_state_type mode_r;
	logic [15:0] cpu_pc, pc0;
	int miscompares = 0;
	int total_checks = 0;
	int n, pc_cnt, pr_cnt;

	pwc_ctrl DUT (.clk_sys(clk_sys), .resetn(resetn), .rst_pin(rst_pin),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_r(reg_rdata_r), .irq_enabled_pending(irq_enabled_pending),
		.wake_pin(wake_pin), .cpu_clk_en_r(cpu_clk_en_r), .cpu_hold_r(cpu_hold_r),
		.irq_vector_r(irq_vector_r), .periph_clk_en_r(periph_clk_en_r),
		.intc_clk_en_r(intc_clk_en_r), .osc_en_r(osc_en_r), .mode_r(mode_r));

	pwc_cpu_model cpu (.clk_sys(clk_sys), .resetn(resetn), .cpu_clk_en_r(cpu_clk_en_r),
		.cpu_hold_r(cpu_hold_r), .irq_vector_r(irq_vector_r), .irq_req(irq_req),
		.irq_enabled_pending(irq_enabled_pending), .cpu_pc(cpu_pc));

	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one-cycle write strobe, released at the taking edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata_r;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	// count enable ticks over eight cycles; phase of a halved clock does not matter
	task automatic cnt8;
		pc_cnt = 0;
		pr_cnt = 0;
		repeat (8) begin
			tick(1);
			pc_cnt += cpu_clk_en_r;
			pr_cnt += periph_clk_en_r;
		end
	endtask

	task automatic wait_run;
		for (n = 0; n < 50 && mode_r !== PWC_ST_RUN; n++)
			tick(1);
		if (n == 50) begin
			miscompares++;
			report_and_stop();
		end
	endtask

	task automatic t_flags;
		rd(4'h0);
		chk("pcr reset", PWC_PCR_RST, rd_val);
		chk("osc on", 8'h01, {7'h00, osc_en_r});
		wr(4'h0, 8'h0c);
		rd(4'h0);
		chk("flags set", 8'h0c, rd_val);
		wr(4'h0, 8'h08);
		rd(4'h0);
		chk("gf1 only", 8'h08, rd_val);
		rd(4'hf);
		chk("unmapped", 8'h00, rd_val);
		$display("test flags done");
	endtask

	task automatic t_idle;
		wr(4'h0, 8'h05);
		tick(1);
		chk("hold", 8'h01, {7'h00, cpu_hold_r});
		chk("cpu stop", 8'h00, {7'h00, cpu_clk_en_r});
		chk("intc run", 8'h01, {7'h00, intc_clk_en_r});
		pc0 = cpu_pc;
		cnt8();
		chk("periph run", 8'h08, pr_cnt[7:0]);
		rd(4'h2);
		chk("status idle", {6'h00, PWC_ST_IDLE}, rd_val);
		chk("pc held", 8'h01, {7'h00, cpu_pc === pc0});
		@(posedge clk_sys);
		irq_req <= 1'b1;
		@(posedge clk_sys);
		irq_req <= 1'b0;
		for (n = 0; n < 50 && irq_vector_r !== 1'b1; n++)
			tick(1);
		chk("vector", 8'h01, {7'h00, irq_vector_r});
		if (n == 50)
			report_and_stop();
		chk("resume point", pc0[7:0], cpu_pc[7:0]);
		tick(3);
		chk("pc moves", 8'h00, {7'h00, cpu_pc === pc0});
		rd(4'h0);
		chk("sleep cleared", 8'h04, rd_val);
		$display("test idle done");
	endtask

	task automatic t_down;
		for (int d = 2; d < 4; d++) begin
			wr(4'h0, d[7:0]);
			tick(2);
			chk("mode down", {6'h00, PWC_ST_DOWN}, {6'h00, mode_r});
			chk("osc off", 8'h00, {7'h00, osc_en_r});
			chk("clocks off", 8'h00, {6'h00, cpu_clk_en_r, periph_clk_en_r});
			@(posedge clk_sys);
			wake_pin <= 1'b1;
			wait_run();
			@(posedge clk_sys);
			wake_pin <= 1'b0;
			rd(4'h0);
			chk("bits cleared", 8'h00, rd_val);
			tick(5);
			chk("stays run", {6'h00, PWC_ST_RUN}, {6'h00, mode_r});
		end
		$display("test down done");
	endtask

	task automatic t_halve;
		wr(4'h1, 8'h01);
		// the enables lag the divider by two flops; let them settle
		tick(2);
		cnt8();
		chk("cpu halved", 8'h04, pc_cnt[7:0]);
		chk("periph halved", 8'h04, pr_cnt[7:0]);
		wr(4'h1, 8'h00);
		tick(2);
		cnt8();
		chk("cpu full", 8'h08, pc_cnt[7:0]);
		$display("test halve done");
	endtask

	task automatic t_rstpin;
		wr(4'h0, 8'h01);
		tick(2);
		chk("idle again", {6'h00, PWC_ST_IDLE}, {6'h00, mode_r});
		@(posedge clk_sys);
		rst_pin <= 1'b1;
		#1;
		// mode_r is registered, so the clear with no edge is seen inside
		chk("async run", {6'h00, PWC_ST_RUN}, {6'h00, DUT.state_r});
		chk("async sleep", 8'h00, {7'h00, DUT.sleep_req_r});
		@(posedge clk_sys);
		rst_pin <= 1'b0;
		#1;
		chk("mode run", {6'h00, PWC_ST_RUN}, {6'h00, mode_r});
		rd(4'h0);
		chk("sleep off", 8'h00, rd_val);
		$display("test rstpin done");
	endtask

	// reset low for three cycles, then the scenarios in turn
	initial begin
		resetn = 1'b0;
		rst_pin = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		wake_pin = 1'b0;
		irq_req = 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		tick(3);
		t_flags();
		t_idle();
		t_down();
		t_halve();
		t_rstpin();
		report_and_stop();
	end
endmodule
